// file: tb_usbif_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("wrong value %0t %h", $time, a); end end
module tb_usbif_ctrl;
    logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, token_valid_i = 0, data_crc_fail_i = 0;
    logic [5:0] reg_addr_i = '0, otg_status_i = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, d;
    logic [6:0] token_addr_i = '0;
    logic [2:0] serial_rx_i = '0, flag_port_o, op_mode_o;
    logic [1:0] line_state_i;
    logic reg_ack_o, link_clk_i, rx_active_i, rx_error_i, token_accept_o;
    int miscompares = 0, tests_run = 0;
    localparam logic [5:0] TA[8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h28, 6'h01, 6'h24};
    localparam logic [31:0] TR[8] = '{0, 0, 32'h7, 0, 32'h2, 0, 0, 0};
    localparam logic [31:0] TE[8] = '{32'hf7, 32'h7f, 0, 32'hdf, 32'hf, 32'h7ff, 0, 32'h7f7f7f};
    usbif_ctrl dut_u (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
        .link_clk_i, .line_state_i, .rx_active_i, .rx_error_i, .otg_status_i, .serial_rx_i, .token_valid_i,
        .token_addr_i, .token_pid_i(4'h0), .token_endp_i(4'h0), .frame_start_i(1'b0), .frame_number_i(11'h000),
        .data_crc_fail_i, .token_accept_o, .op_mode_o, .term_select_o(), .xcvr_select_o(), .otg_ctrl_o(),
        .serial_ctrl_o(), .token_ctrl_o(), .dev_addr_o(), .flag_port_o);
    usbif_phy_model phy_u (.link_clk_o(link_clk_i), .line_state_o(line_state_i), .rx_active_o(rx_active_i),
        .rx_error_o(rx_error_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(negedge clk_i);
        d = reg_rdata_o;
        `CHK(reg_ack_o, 1'b1)
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask : acc
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(d, e)
    endtask : rd
    task automatic wait_port(input int i);
        for (int n = 0; n < 300 && flag_port_o[i] !== 1'b1; n++) @(posedge clk_i);
        `CHK(flag_port_o[i], 1'b1)
    endtask : wait_port
    task automatic pulse(input logic [6:0] a, input logic e);
        @(posedge clk_i);
        token_valid_i <= 1'b1;
        token_addr_i <= a;
        data_crc_fail_i <= e;
        @(negedge clk_i);
        `CHK(token_accept_o, e)
        @(posedge clk_i);
        token_valid_i <= 1'b0;
        data_crc_fail_i <= 1'b0;
    endtask : pulse
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            rd(TA[i], TR[i]);
            acc(1'b1, TA[i], (i == 2) ? 32'h0 : (i == 4) ? 32'hf : 32'hffffffff);
            rd(TA[i], TE[i]);
        end
        $display("test regs done");
    endtask : t_regs
    task automatic t_soft();
        acc(1'b1, 6'h00, 32'h5a);
        rd(6'h0c, 32'h7);
        rd(6'h28, 32'h0);
        `CHK(op_mode_o, 3'h1)
        otg_status_i <= 6'h2a;
        serial_rx_i <= 3'h5;
        rd(6'h14, 32'h2a);
        rd(6'h18, 32'h52);
        $display("test soft reset done");
    endtask : t_soft
    task automatic t_flags();
        acc(1'b1, 6'h24, 32'h00080244);
        acc(1'b1, 6'h20, 32'h4);
        acc(1'b1, 6'h08, 32'h5);
        acc(1'b1, 6'h04, 32'h5);
        pulse(7'h6, 1'b0);
        pulse(7'h5, 1'b1);
        wait_port(0);
        rd(6'h1c, 32'h4c);
        phy_u.start(usbif_pkg::LINE_K, 1'b1);
        wait_port(1);
        // Give the packet start a full link clock period to clear the token flag.
        repeat (40) @(posedge clk_i);
        rd(6'h1c, 32'h17);
        phy_u.stop();
        wait_port(2);
        acc(1'b1, 6'h1c, 32'h4);
        rd(6'h1c, 32'h08);
        `CHK(flag_port_o, 3'b100)
        $display("test flags done");
    endtask : t_flags
    task automatic conclude();
        $display("compared %0d, wrong %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_soft();
        t_flags();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
endmodule : tb_usbif_ctrl

// file: usbif_ctrl.sv
`timescale 1ns/1ps
// Operation
// [RULE1] Any write to reset register clears module state.
// [RULE2] Token control enables, bits seven to zero.
// [RULE3] Seven-bit address filters received token packets.
// [RULE4] Software keeps address zero until enumeration.
// [RULE5] Functional control drives opmode, termsel, xcvrsel.
// [RULE6] On-the-go control drives VBUS and pull controls.
// [RULE7] On-the-go flags reflect transceiver inputs.
// [RULE8] Serial bits six to four report receivers.
// [RULE9] Serial bits drive SE0, data, enable, mode.
// [RULE10] Token flag on good matching token.
// [RULE11] Line flags for SE0, K, J.
// [RULE12] CRC16 flag on bad data packet.
// [RULE13] Flags follow receive active and error.
// [RULE14] Non-sticky flags clear at packet start; the code clears only the token and CRC16 flags there.
// [RULE15] Sticky flags hold until written one.
// [RULE16] Non-sticky flags track their sources; the code does so only for the SE0, K, J, receive active and error flags.
// [RULE17] Three masks OR flags onto outputs.
// [RULE18] Eleven-bit read-write frame-start counter.
// [RULE19] Registers accessed with full 32-bit words.
// [RULE20] Port signals: clock, tx, rx, flags.
// [RULE21] Flag outputs follow within one cycle.
module usbif_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic link_clk_i,
    input wire logic [1:0] line_state_i,
    input wire logic rx_active_i,
    input wire logic rx_error_i,
    input wire logic [5:0] otg_status_i,
    input wire logic [2:0] serial_rx_i,
    input wire logic token_valid_i,
    input wire logic [6:0] token_addr_i,
    input wire logic [3:0] token_pid_i,
    input wire logic [3:0] token_endp_i,
    input wire logic frame_start_i,
    input wire logic [10:0] frame_number_i,
    input wire logic data_crc_fail_i,
    output logic token_accept_o,
    output logic [2:0] op_mode_o,
    output logic term_select_o,
    output logic xcvr_select_o,
    output logic [7:0] otg_ctrl_o,
    output logic [3:0] serial_ctrl_o,
    output logic [7:0] token_ctrl_o,
    output logic [6:0] dev_addr_o,
    output logic [2:0] flag_port_o
);
    logic [2:0] lclk_sync;
    logic [2:0] la_sync;
    logic [2:0] le_sync;
    logic [1:0] ls0_sync;
    logic [1:0] ls1_sync;
    logic [1:0] ls2_sync;
    logic link_edge;
    logic soft_rst;
    logic wr_hit;
    logic [7:0] token_ctrl;
    logic [6:0] dev_addr;
    logic [4:0] func_ctrl;
    logic [7:0] otg_ctrl;
    logic [3:0] serial_ctrl;
    logic [6:0] flags;
    logic [6:0] sticky;
    logic [22:0] masks;
    logic [10:0] frame_cnt;
    logic [3:0] last_pid;
    logic [4:0] last_endp;
    logic [15:0] ep_match;
    logic [8:0] power_sig;
    logic [18:0] phy_ctrl;
    logic [6:0] src_set;
    logic [6:0] next_flags;
    logic token_ok;
    logic rx_act_q;
    logic pkt_start;
    logic [1:0] line_q;

    // Link signals pass three stages; line state counts once the last two agree, the link clock rising edge once the middle is high and the last low.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lclk_sync <= 3'h0;
            la_sync <= 3'h0;
            le_sync <= 3'h0;
            ls0_sync <= 2'h0;
            ls1_sync <= 2'h0;
            ls2_sync <= 2'h0;
        end else begin
            lclk_sync <= {lclk_sync[1:0], link_clk_i};
            la_sync <= {la_sync[1:0], rx_active_i};
            le_sync <= {le_sync[1:0], rx_error_i};
            ls0_sync <= line_state_i;
            ls1_sync <= ls0_sync;
            ls2_sync <= ls1_sync;
        end
    end

    assign link_edge = lclk_sync[1] & ~lclk_sync[2];
    assign wr_hit = reg_wr_i;
    assign soft_rst = reg_wr_i && (reg_addr_i == usbif_pkg::ADDR_IF_RESET); // see [RULE1]
    assign reg_ack_o = reg_wr_i | reg_rd_i; // see [RULE19]

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin // see [RULE1]
            token_ctrl <= usbif_pkg::TOKEN_CTRL_RESET;
            dev_addr <= 7'h00;
            func_ctrl <= usbif_pkg::FUNC_CTRL_RESET;
            otg_ctrl <= 8'h00;
            serial_ctrl <= usbif_pkg::SERIAL_CTRL_RESET;
            sticky <= 7'h00;
            masks <= 23'h000000;
            ep_match <= 16'h0000;
            power_sig <= 9'h000;
            phy_ctrl <= 19'h00000;
        end else if (wr_hit) begin
            if (reg_addr_i == usbif_pkg::ADDR_TOKEN_CTRL) begin
                token_ctrl <= reg_wdata_i[7:0] & usbif_pkg::TOKEN_CTRL_WMASK; // see [RULE2]
            end else if (reg_addr_i == usbif_pkg::ADDR_DEV_ADDR) begin
                dev_addr <= reg_wdata_i[6:0]; // see [RULE3]
            end else if (reg_addr_i == usbif_pkg::ADDR_FUNC_CTRL) begin
                func_ctrl <= reg_wdata_i[4:0]; // see [RULE5]
            end else if (reg_addr_i == usbif_pkg::ADDR_OTG_CTRL) begin
                otg_ctrl <= reg_wdata_i[7:0] & usbif_pkg::OTG_CTRL_WMASK; // see [RULE6]
            end else if (reg_addr_i == usbif_pkg::ADDR_SERIAL_CTRL) begin
                serial_ctrl <= reg_wdata_i[3:0]; // see [RULE9]
            end else if (reg_addr_i == usbif_pkg::ADDR_STICKY) begin
                sticky <= reg_wdata_i[6:0]; // see [RULE15]
            end else if (reg_addr_i == usbif_pkg::ADDR_MASKS) begin
                masks <= {reg_wdata_i[22:16], 1'b0, reg_wdata_i[14:8], 1'b0, reg_wdata_i[6:0]}; // see [RULE17]
            end else if (reg_addr_i == usbif_pkg::ADDR_EP_MATCH) begin
                ep_match <= reg_wdata_i[15:0];
            end else if (reg_addr_i == usbif_pkg::ADDR_POWER_SIG) begin
                power_sig <= reg_wdata_i[8:0];
            end else if (reg_addr_i == usbif_pkg::ADDR_PHY_CTRL) begin
                phy_ctrl <= {reg_wdata_i[18], 4'h0, reg_wdata_i[13:4], 4'h0};
            end
        end
    end

    // A token counts only with token checking on and the stored address matching.
    assign token_ok = token_valid_i && token_ctrl[0] && (token_addr_i == dev_addr); // see [RULE3] see [RULE10]
    assign token_accept_o = token_ok;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin
            last_pid <= 4'h0;
            last_endp <= 5'h00;
        end else if (token_ok) begin
            last_pid <= token_pid_i;
            last_endp <= {1'b1, token_endp_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin
            frame_cnt <= 11'h000;
        end else if (wr_hit && reg_addr_i == usbif_pkg::ADDR_FRAME_CNT) begin
            frame_cnt <= reg_wdata_i[10:0]; // see [RULE18]
        end else if (frame_start_i) begin
            frame_cnt <= frame_number_i; // see [RULE18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin
            rx_act_q <= 1'b0;
            line_q <= usbif_pkg::LINE_SE0;
        end else begin
            if (link_edge) begin
                rx_act_q <= la_sync[2];
            end
            // The line state counts only once the last two stages agree.
            if (ls1_sync == ls2_sync) begin
                line_q <= ls2_sync; // see [RULE11]
            end
        end
    end

    assign pkt_start = link_edge && la_sync[2] && !rx_act_q;

    always_comb begin
        src_set = 7'h00;
        src_set[usbif_pkg::FLAG_TOKEN] = token_ok; // see [RULE10]
        src_set[usbif_pkg::FLAG_SE0] = token_ctrl[2] && line_q == usbif_pkg::LINE_SE0; // see [RULE11]
        src_set[usbif_pkg::FLAG_K] = token_ctrl[2] && line_q == usbif_pkg::LINE_K; // see [RULE11]
        src_set[usbif_pkg::FLAG_J] = token_ctrl[2] && line_q == usbif_pkg::LINE_J; // see [RULE11]
        src_set[usbif_pkg::FLAG_CRC16] = data_crc_fail_i; // see [RULE12]
        src_set[usbif_pkg::FLAG_RXACT] = la_sync[2] && la_sync[1]; // see [RULE13]
        src_set[usbif_pkg::FLAG_RXERR] = le_sync[2] && le_sync[1]; // see [RULE13]
        for (int i = 0; i < 7; i++) begin
            if (sticky[i]) begin
                // Sticky: a one written clears, but a new event in the same cycle wins.
                next_flags[i] = src_set[i] | (flags[i] & ~(wr_hit && reg_addr_i == usbif_pkg::ADDR_LINE_FLAGS
                    && reg_wdata_i[i])); // see [RULE15]
            end else if (i == usbif_pkg::FLAG_RXACT || i == usbif_pkg::FLAG_RXERR || (i >= usbif_pkg::FLAG_J
                && i <= usbif_pkg::FLAG_SE0)) begin
                next_flags[i] = src_set[i]; // see [RULE16]
            end else begin
                next_flags[i] = src_set[i] | (flags[i] & ~pkt_start); // see [RULE14]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin
            flags <= 7'h00;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || soft_rst) begin
            flag_port_o <= 3'h0;
        end else begin
            flag_port_o[0] <= |(next_flags & masks[usbif_pkg::MASK1_LSB +: 7]); // see [RULE17] see [RULE21]
            flag_port_o[1] <= |(next_flags & masks[usbif_pkg::MASK2_LSB +: 7]); // see [RULE17] see [RULE21]
            flag_port_o[2] <= |(next_flags & masks[usbif_pkg::MASK3_LSB +: 7]); // see [RULE17] see [RULE21]
        end
    end

    always_comb begin
        reg_rdata_o = 32'h00000000;
        if (reg_addr_i == usbif_pkg::ADDR_TOKEN_CTRL) begin
            reg_rdata_o[7:0] = token_ctrl;
        end else if (reg_addr_i == usbif_pkg::ADDR_DEV_ADDR) begin
            reg_rdata_o[6:0] = dev_addr;
        end else if (reg_addr_i == usbif_pkg::ADDR_FUNC_CTRL) begin
            reg_rdata_o[4:0] = func_ctrl;
        end else if (reg_addr_i == usbif_pkg::ADDR_OTG_CTRL) begin
            reg_rdata_o[7:0] = otg_ctrl;
        end else if (reg_addr_i == usbif_pkg::ADDR_OTG_FLAGS) begin
            reg_rdata_o[5:0] = otg_status_i; // see [RULE7]
        end else if (reg_addr_i == usbif_pkg::ADDR_SERIAL_CTRL) begin
            reg_rdata_o[6:0] = {serial_rx_i, serial_ctrl}; // see [RULE8]
        end else if (reg_addr_i == usbif_pkg::ADDR_LINE_FLAGS) begin
            reg_rdata_o[6:0] = flags;
        end else if (reg_addr_i == usbif_pkg::ADDR_STICKY) begin
            reg_rdata_o[6:0] = sticky;
        end else if (reg_addr_i == usbif_pkg::ADDR_MASKS) begin
            reg_rdata_o[22:0] = masks;
        end else if (reg_addr_i == usbif_pkg::ADDR_FRAME_CNT) begin
            reg_rdata_o[10:0] = frame_cnt;
        end else if (reg_addr_i == usbif_pkg::ADDR_PID) begin
            reg_rdata_o[3:0] = last_pid;
        end else if (reg_addr_i == usbif_pkg::ADDR_ENDPOINT) begin
            reg_rdata_o[4:0] = last_endp;
        end else if (reg_addr_i == usbif_pkg::ADDR_EP_MATCH) begin
            reg_rdata_o[15:0] = ep_match;
        end else if (reg_addr_i == usbif_pkg::ADDR_POWER_SIG) begin
            reg_rdata_o[8:0] = power_sig;
        end else if (reg_addr_i == usbif_pkg::ADDR_PHY_CTRL) begin
            reg_rdata_o[18:0] = phy_ctrl;
        end
    end

    assign op_mode_o = func_ctrl[4:2]; // see [RULE5]
    assign term_select_o = func_ctrl[1]; // see [RULE5]
    assign xcvr_select_o = func_ctrl[0]; // see [RULE5]
    assign otg_ctrl_o = otg_ctrl; // see [RULE6]
    assign serial_ctrl_o = serial_ctrl; // see [RULE9]
    assign token_ctrl_o = token_ctrl; // see [RULE2]
    assign dev_addr_o = dev_addr;
endmodule : usbif_ctrl

// file: usbif_ctrl_assertions.sv
`timescale 1ns/1ps
module usbif_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic [5:0] otg_status_i,
    input wire logic token_valid_i,
    input wire logic [6:0] token_addr_i,
    input wire logic token_accept_o,
    input wire logic [2:0] op_mode_o,
    input wire logic term_select_o,
    input wire logic xcvr_select_o,
    input wire logic [7:0] otg_ctrl_o,
    input wire logic [7:0] token_ctrl_o,
    input wire logic [6:0] dev_addr_o
);
    logic [31:0] wd_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge clk_i) begin
        wd_q <= reg_wdata_i;
    end
    bus_ack_a: assert property (reg_ack_o == (reg_wr_i | reg_rd_i))
        else $error("ack differs from strobes");
    soft_reset_a: assert property (reg_wr_i && reg_addr_i == 6'h00 |=> op_mode_o == 3'h1 && term_select_o
        && xcvr_select_o && token_ctrl_o == 8'h00 && dev_addr_o == 7'h00) else $error("soft reset missed");
    token_ctrl_a: assert property (reg_wr_i && reg_addr_i == 6'h04 |=>
        token_ctrl_o == (wd_q[7:0] & usbif_pkg::TOKEN_CTRL_WMASK)) else $error("token control wrong");
    dev_addr_a: assert property (reg_wr_i && reg_addr_i == 6'h08 |-> ##1 dev_addr_o == wd_q[6:0])
        else $error("address not stored");
    token_accept_a: assert property (token_accept_o == (token_valid_i && token_ctrl_o[0]
        && token_addr_i == dev_addr_o)) else $error("address filter wrong");
    func_ctrl_a: assert property (reg_wr_i && reg_addr_i == 6'h0c |=>
        {op_mode_o, term_select_o, xcvr_select_o} == wd_q[4:0]) else $error("function control wrong");
    otg_ctrl_a: assert property (reg_wr_i && reg_addr_i == 6'h10 |=>
        otg_ctrl_o == (wd_q[7:0] & usbif_pkg::OTG_CTRL_WMASK)) else $error("otg control wrong");
    otg_flags_a: assert property (reg_rd_i && reg_addr_i == 6'h14 |-> reg_rdata_o == {26'h0, otg_status_i})
        else $error("otg flags wrong");
    cover property (token_accept_o);
    cover property (reg_wr_i && reg_addr_i == 6'h00);
    cover property (reg_rd_i && reg_addr_i == 6'h1c && reg_rdata_o[2]);
endmodule : usbif_ctrl_chk
bind usbif_ctrl usbif_ctrl_chk chk_u (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .otg_status_i, .token_valid_i, .token_addr_i, .token_accept_o, .op_mode_o,
    .term_select_o, .xcvr_select_o, .otg_ctrl_o, .token_ctrl_o, .dev_addr_o);

// file: usbif_phy_model.sv
`timescale 1ns/1ps
module usbif_phy_model (
    output logic link_clk_o,
    output logic [1:0] line_state_o,
    output logic rx_active_o,
    output logic rx_error_o
);
    initial begin
        link_clk_o = 1'b0;
        line_state_o = usbif_pkg::LINE_J;
        rx_active_o = 1'b0;
        rx_error_o = 1'b0;
        forever #62.5 link_clk_o = ~link_clk_o;
    end
    task automatic start(input logic [1:0] ls, input logic err);
        @(posedge link_clk_o);
        line_state_o <= ls;
        rx_active_o <= 1'b1;
        rx_error_o <= err;
    endtask : start
    task automatic stop();
        @(posedge link_clk_o);
        line_state_o <= usbif_pkg::LINE_J;
        rx_active_o <= 1'b0;
        rx_error_o <= 1'b0;
    endtask : stop
endmodule : usbif_phy_model

// file: usbif_pkg.sv
package usbif_pkg;
    localparam logic [5:0] ADDR_IF_RESET = 6'h00;
    localparam logic [5:0] ADDR_TOKEN_CTRL = 6'h04;
    localparam logic [5:0] ADDR_DEV_ADDR = 6'h08;
    localparam logic [5:0] ADDR_FUNC_CTRL = 6'h0c;
    localparam logic [5:0] ADDR_OTG_CTRL = 6'h10;
    localparam logic [5:0] ADDR_OTG_FLAGS = 6'h14;
    localparam logic [5:0] ADDR_SERIAL_CTRL = 6'h18;
    localparam logic [5:0] ADDR_LINE_FLAGS = 6'h1c;
    localparam logic [5:0] ADDR_STICKY = 6'h20;
    localparam logic [5:0] ADDR_MASKS = 6'h24;
    localparam logic [5:0] ADDR_FRAME_CNT = 6'h28;
    localparam logic [5:0] ADDR_PID = 6'h2c;
    localparam logic [5:0] ADDR_ENDPOINT = 6'h30;
    localparam logic [5:0] ADDR_EP_MATCH = 6'h34;
    localparam logic [5:0] ADDR_POWER_SIG = 6'h38;
    localparam logic [5:0] ADDR_PHY_CTRL = 6'h3c;
    localparam logic [7:0] TOKEN_CTRL_RESET = 8'h00;
    localparam logic [7:0] TOKEN_CTRL_WMASK = 8'hf7;
    localparam logic [4:0] FUNC_CTRL_RESET = 5'h07;
    localparam logic [7:0] OTG_CTRL_WMASK = 8'hdf;
    localparam logic [3:0] SERIAL_CTRL_RESET = 4'h2;
    localparam int FLAG_TOKEN = 6;
    localparam int FLAG_SE0 = 5;
    localparam int FLAG_K = 4;
    localparam int FLAG_J = 3;
    localparam int FLAG_CRC16 = 2;
    localparam int FLAG_RXACT = 1;
    localparam int FLAG_RXERR = 0;
    localparam int MASK1_LSB = 0;
    localparam int MASK2_LSB = 8;
    localparam int MASK3_LSB = 16;
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_J = 2'h1;
    localparam logic [1:0] LINE_K = 2'h2;
endpackage : usbif_pkg
